// *** shared/sps_pkg.sv ***
// constants, types and timing for the sleep pin and serial port sequencing pair
package sps_pkg;
	// =====================================================================
	// clock and times in their own units
	localparam int unsigned CLK_HZ        = 125000000;
	localparam int unsigned CLK_NS        = 8;
	localparam int unsigned T_SWR_NS      = 100000;
	localparam int unsigned T_SRW_NS      = 120;
	localparam int unsigned T_SRR_NS      = 120;
	localparam int unsigned T_SWW_NS      = 100000;
	localparam int unsigned T_HOLD_NS     = 100000;
	localparam int unsigned T_COMPUTE_NS  = 3200000;
	localparam int unsigned T_PDW_NS      = 700000;
	localparam int unsigned T_PD_RST_NS   = 100000;
	localparam int unsigned T_PDOWN_NS    = 700000;
	localparam int unsigned T_WAKE_NS     = 705000;
	localparam int unsigned T_SPTT_NS     = 900000000;
	localparam int unsigned T_STEP_NS     = 133000;
	localparam int unsigned FRAME_RATE    = 1500;
	localparam int unsigned FRAMES_SLEEP  = 75;
	localparam int unsigned FRAMES_RESET  = 40;
	// =====================================================================
	// cycle counts: least times round up, longest times round down
	localparam int unsigned SWR_CYC     = (T_SWR_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SRW_CYC     = (T_SRW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SRR_CYC     = (T_SRR_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SWW_CYC     = (T_SWW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned COMPUTE_CYC = (T_COMPUTE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PDW_CYC     = (T_PDW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PD_RST_CYC  = (T_PD_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PDOWN_CYC   = T_PDOWN_NS / CLK_NS;
	localparam int unsigned WAKE_CYC    = T_WAKE_NS / CLK_NS;
	localparam int unsigned SPTT_CYC    = T_SPTT_NS / CLK_NS;
	localparam int unsigned STEP_CYC    = (T_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned FRAME_CYC   = CLK_HZ / FRAME_RATE;
	// half period of the serial clock in system cycles; 8 gives 1/16
	localparam int unsigned SCLK_HALF   = 8;
	// =====================================================================
	// serial frame layout and device register indexes
	localparam int unsigned WRITE_BIT      = 7;
	localparam int unsigned LAST_BIT       = 7;
	localparam logic [2:0]  REG_ID         = 3'h0;
	localparam logic [2:0]  REG_STATUS     = 3'h1;
	localparam logic [2:0]  REG_MOT_X      = 3'h2;
	localparam logic [2:0]  REG_MOT_Y      = 3'h3;
	localparam logic [2:0]  REG_FRAME_TRIM = 3'h4;
	localparam int unsigned TRIM_SHIFT     = 8;
	// arbitrary identity value
	localparam logic [7:0]  ID_VALUE       = 8'h5a;
	localparam logic [7:0]  TRIM_RESET     = 8'h00;
	// =====================================================================
	typedef enum logic [2:0] {
		PS_ADDR  = 3'b001,
		PS_WDATA = 3'b010,
		PS_RDATA = 3'b100
	} sps_port_e;
	typedef enum logic [1:0] {
		PW_RUN  = 2'b01,
		PW_DOWN = 2'b10
	} sps_pwr_e;
	typedef enum logic [5:0] {
		HS_IDLE  = 6'b000001,
		HS_ADDR  = 6'b000010,
		HS_HOLD  = 6'b000100,
		HS_RDATA = 6'b001000,
		HS_WDATA = 6'b010000,
		HS_GAP   = 6'b100000
	} sps_host_e;
endpackage

// *** shared/sps_if.sv ***
// link between motion sensor end and controller end
`timescale 1ns/100ps
interface sps_if;
	logic sclk;
	logic sdioHost;
	logic sdioHostOeN;
	logic sdioDev;
	logic sdioDevOeN;
	logic sdio;
	logic sleepRequestPin;
	logic horizontalPhaseA;
	logic horizontalPhaseB;
	logic verticalPhaseA;
	logic verticalPhaseB;
	// pulled high when neither end drives
	assign sdio = !sdioDevOeN ? sdioDev : (!sdioHostOeN ? sdioHost : 1'b1);
	modport dev (
		input  sclk,
		input  sdio,
		input  sleepRequestPin,
		output sdioDev,
		output sdioDevOeN,
		output horizontalPhaseA,
		output horizontalPhaseB,
		output verticalPhaseA,
		output verticalPhaseB
	);
	modport host (
		output sclk,
		output sdioHost,
		output sdioHostOeN,
		output sleepRequestPin,
		input  sdio
	);
endinterface

// *** hw/sps_device_end.sv ***
// motion sensor end: serial port slave, sleep handling, frames, quadrature
`timescale 1ns/100ps
module sps_device_end #(
	parameter int unsigned FRAME_CYC   = sps_pkg::FRAME_CYC,
	parameter int unsigned COMPUTE_CYC = sps_pkg::COMPUTE_CYC,
	parameter int unsigned PD_RST_CYC  = sps_pkg::PD_RST_CYC,
	parameter int unsigned PDOWN_CYC   = sps_pkg::PDOWN_CYC,
	parameter int unsigned WAKE_CYC    = sps_pkg::WAKE_CYC,
	parameter int unsigned SPTT_CYC    = sps_pkg::SPTT_CYC,
	parameter int unsigned STEP_CYC    = sps_pkg::STEP_CYC
) (
	input  logic        mclk,
	input  logic        rst_n,
	sps_if.dev          link,
	input  logic        motionValid,
	input  logic [7:0]  deltaX,
	input  logic [7:0]  deltaY,
	output logic        quadValid,
	output logic        dataReady,
	output logic        poweredDown,
	output logic        frameTick
);
	import sps_pkg::*;

	typedef struct packed {
		sps_port_e        port;
		sps_pwr_e         pwr;
		logic [1:0]       sclkS;
		logic [2:0]       sdioS;
		logic [1:0]       sleepS;
		logic             sclkPrev;
		logic             sleepPrev;
		logic [3:0]       bitCnt;
		logic [7:0]       shift;
		logic [2:0]       addr;
		logic             sdoOut;
		logic             sdoOeN;
		logic             active;
		logic [31:0]      toCnt;
		logic [31:0]      sleepCnt;
		logic [31:0]      wakeCnt;
		logic [31:0]      frameCnt;
		logic [7:0]       frames;
		logic [7:0]       needFrames;
		logic             quadValid;
		logic             dataReady;
		logic             frameTick;
		logic [7:0]       motX;
		logic [7:0]       motY;
		logic [7:0]       frameTrim;
		logic [11:0]      pendX;
		logic [11:0]      pendY;
		logic [1:0]       phX;
		logic [1:0]       phY;
		logic [31:0]      stepCnt;
	} sps_dev_s;

	localparam logic [7:0] FRAMES_RESET_B = 8'(FRAMES_RESET);
	localparam logic [7:0] FRAMES_SLEEP_B = 8'(FRAMES_SLEEP);

	sps_dev_s s;
	sps_dev_s next_s;
	logic     sclkRise;
	logic     sclkFall;
	logic     sleeping;
	logic [31:0] framePeriod;

	// =====================================================================
	// helpers
	function automatic logic [1:0] quadStep(input logic [1:0] ph, input logic up);
		logic [1:0] r;
		r = ph;
		case (ph)
			2'h0: r = up ? 2'h1 : 2'h2;
			2'h1: r = up ? 2'h3 : 2'h0;
			2'h3: r = up ? 2'h2 : 2'h1;
			2'h2: r = up ? 2'h0 : 2'h3;
			default: r = 2'h0;
		endcase
		return r;
	endfunction

	// one count toward zero per step; returns the new pending value
	function automatic logic [11:0] towardZero(input logic [11:0] p);
		return p[11] ? 12'(p + 12'h001) : 12'(p - 12'h001);
	endfunction

	function automatic logic [11:0] sext(input logic [7:0] d);
		return {{4{d[7]}}, d};
	endfunction

	function automatic logic [7:0] regRead(input sps_dev_s v);
		logic [7:0] r;
		r = 8'h00;
		case (v.addr)
			REG_ID:         r = ID_VALUE;
			REG_STATUS:     r = {5'h00, v.pwr == PW_DOWN, v.quadValid, v.dataReady};
			REG_MOT_X:      r = v.motX;
			REG_MOT_Y:      r = v.motY;
			REG_FRAME_TRIM: r = v.frameTrim;
			default:        r = 8'h00;
		endcase
		return r;
	endfunction

	assign sclkRise    = s.sclkS[1] & ~s.sclkPrev;
	assign sclkFall    = ~s.sclkS[1] & s.sclkPrev;
	assign sleeping    = s.sleepS[1];
	// trim lengthens the frame in steps of 256 cycles
	assign framePeriod = FRAME_CYC + (32'(s.frameTrim) << TRIM_SHIFT);

	// =====================================================================
	// next state
	always_comb
	begin
		next_s = s;
		next_s.sclkS     = {s.sclkS[0], link.sclk};
		// third stage matches the edge detect, so data is taken as it stood before the rise
		next_s.sdioS     = {s.sdioS[1:0], link.sdio};
		next_s.sleepS    = {s.sleepS[0], link.sleepRequestPin};
		next_s.sclkPrev  = s.sclkS[1];
		next_s.sleepPrev = s.sleepS[1];
		next_s.frameTick = 1'b0;

		// serial port slave
		if (sclkRise)
		begin
			next_s.active = 1'b1;
			// read data moves out on falls only; shifting here too would skip bits
			if (s.port != PS_RDATA)
			begin
				next_s.shift = {s.shift[6:0], s.sdioS[2]};
			end
			next_s.bitCnt = 4'(s.bitCnt + 4'h1);
			if (s.bitCnt == 4'(LAST_BIT))
			begin
				next_s.bitCnt = 4'h0;
				case (s.port)
					PS_ADDR:
					begin
						next_s.addr = next_s.shift[2:0];
						if (next_s.shift[WRITE_BIT])
						begin
							next_s.port = PS_WDATA;
						end
						else
						begin
							next_s.port  = PS_RDATA;
							next_s.shift = regRead(next_s);
						end
					end
					PS_WDATA:
					begin
						if (s.addr == REG_FRAME_TRIM)
						begin
							next_s.frameTrim = next_s.shift;
						end
						next_s.port   = PS_ADDR;
						next_s.active = 1'b0;
						next_s.toCnt  = 32'h0;
					end
					PS_RDATA:
					begin
						next_s.sdoOeN = 1'b1;
						next_s.port   = PS_ADDR;
						next_s.active = 1'b0;
						next_s.toCnt  = 32'h0;
					end
					default: next_s.port = PS_ADDR;
				endcase
			end
		end
		if (sclkFall && s.port == PS_RDATA)
		begin
			next_s.sdoOeN = 1'b0;
			next_s.sdoOut = s.shift[7];
			next_s.shift  = {s.shift[6:0], 1'b0};
		end
		if (s.active)
		begin
			next_s.toCnt = 32'(s.toCnt + 32'h1);
		end
		// a stalled transaction or a long enough sleep pulse drops the port
		if ((s.active && s.toCnt >= SPTT_CYC - 1) || (sleeping && s.sleepCnt >= PD_RST_CYC - 1))
		begin
			next_s.port   = PS_ADDR;
			next_s.bitCnt = 4'h0;
			next_s.active = 1'b0;
			next_s.toCnt  = 32'h0;
			next_s.sdoOeN = 1'b1;
		end

		// sleep and power
		if (sleeping)
		begin
			if (s.sleepCnt != 32'hffffffff)
			begin
				next_s.sleepCnt = 32'(s.sleepCnt + 32'h1);
			end
			if (s.sleepCnt >= PDOWN_CYC - 1)
			begin
				next_s.pwr       = PW_DOWN;
				next_s.quadValid = 1'b0;
				next_s.dataReady = 1'b0;
			end
		end
		else
		begin
			next_s.sleepCnt = 32'h0;
		end
		if (!sleeping && s.sleepPrev && s.pwr == PW_DOWN)
		begin
			next_s.pwr        = PW_RUN;
			next_s.wakeCnt    = 32'h0;
			next_s.frameCnt   = 32'h0;
			next_s.frames     = 8'h00;
			next_s.needFrames = FRAMES_SLEEP_B;
		end

		// frame capture while awake
		if (s.pwr == PW_RUN && !sleeping)
		begin
			if (s.wakeCnt != 32'hffffffff)
			begin
				next_s.wakeCnt = 32'(s.wakeCnt + 32'h1);
			end
			next_s.frameCnt = 32'(s.frameCnt + 32'h1);
			if (s.frameCnt >= framePeriod - 1)
			begin
				next_s.frameCnt  = 32'h0;
				next_s.frameTick = 1'b1;
				next_s.motX      = s.pendX[7:0];
				next_s.motY      = s.pendY[7:0];
				if (s.frames != 8'hff)
				begin
					next_s.frames = 8'(s.frames + 8'h01);
				end
			end
			if (s.wakeCnt >= COMPUTE_CYC - 1 && s.frames != 8'h00)
			begin
				next_s.dataReady = 1'b1;
			end
			if (s.wakeCnt >= WAKE_CYC - 1 && s.frames >= s.needFrames)
			begin
				next_s.quadValid = 1'b1;
			end
			if (motionValid)
			begin
				next_s.pendX = 12'(s.pendX + sext(deltaX));
				next_s.pendY = 12'(s.pendY + sext(deltaY));
			end
		end

		// quadrature: frozen while sleeping, resumes from the held phase
		if (!sleeping && s.quadValid)
		begin
			next_s.stepCnt = 32'(s.stepCnt + 32'h1);
			if (s.stepCnt >= STEP_CYC - 1)
			begin
				next_s.stepCnt = 32'h0;
				if (s.pendX != 12'h000)
				begin
					next_s.phX   = quadStep(s.phX, ~s.pendX[11]);
					next_s.pendX = towardZero(next_s.pendX);
				end
				if (s.pendY != 12'h000)
				begin
					next_s.phY   = quadStep(s.phY, ~s.pendY[11]);
					next_s.pendY = towardZero(next_s.pendY);
				end
			end
		end
	end

	// =====================================================================
	// state register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s            <= '0;
			s.port       <= PS_ADDR;
			s.pwr        <= PW_RUN;
			s.sdoOeN     <= 1'b1;
			// serial clock idles high: no false rise right after reset
			s.sclkS      <= 2'h3;
			s.sclkPrev   <= 1'b1;
			s.needFrames <= FRAMES_RESET_B;
			s.frameTrim  <= TRIM_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign link.sdioDev          = s.sdoOut;
	assign link.sdioDevOeN       = s.sdoOeN;
	assign link.horizontalPhaseA = s.phX[1];
	assign link.horizontalPhaseB = s.phX[0];
	assign link.verticalPhaseA   = s.phY[1];
	assign link.verticalPhaseB   = s.phY[0];
	assign quadValid             = s.quadValid;
	assign dataReady             = s.dataReady;
	assign poweredDown           = (s.pwr == PW_DOWN);
	assign frameTick             = s.frameTick;
endmodule

// *** hw/sps_host_end.sv ***
// controller end: serial clock master, command spacing, sleep pin driver
`timescale 1ns/100ps
module sps_host_end #(
	parameter int unsigned SCLK_HALF  = sps_pkg::SCLK_HALF,
	parameter int unsigned SWR_CYC    = sps_pkg::SWR_CYC,
	parameter int unsigned SWW_CYC    = sps_pkg::SWW_CYC,
	parameter int unsigned SRW_CYC    = sps_pkg::SRW_CYC,
	parameter int unsigned SRR_CYC    = sps_pkg::SRR_CYC,
	parameter int unsigned HOLD_CYC   = sps_pkg::HOLD_CYC,
	parameter int unsigned PD_RST_CYC = sps_pkg::PD_RST_CYC,
	parameter int unsigned PDW_CYC    = sps_pkg::PDW_CYC
) (
	input  logic        mclk,
	input  logic        rst_n,
	sps_if.host         link,
	input  logic        cmdValid,
	input  logic        cmdWrite,
	input  logic [6:0]  cmdAddr,
	input  logic [7:0]  cmdData,
	output logic        cmdReady,
	output logic [7:0]  rdData,
	output logic        rdValid,
	input  logic        sleepReq,
	output logic        sleepLong
);
	import sps_pkg::*;

	typedef struct packed {
		sps_host_e   st;
		logic [1:0]  sdioS;
		logic [7:0]  divCnt;
		logic        sclk;
		logic        sdoOeN;
		logic [3:0]  bitCnt;
		logic [7:0]  shift;
		logic        isWrite;
		logic [7:0]  wdata;
		logic [31:0] gapCnt;
		logic [31:0] gapLen;
		logic [7:0]  rdData;
		logic        rdValid;
		logic        sleepPin;
		logic [31:0] sleepCnt;
	} sps_host_s;

	// either gap is long enough for whichever command follows
	localparam int unsigned AFTER_WRITE = (SWR_CYC > SWW_CYC) ? SWR_CYC : SWW_CYC;
	localparam int unsigned AFTER_READ  = (SRW_CYC > SRR_CYC) ? SRW_CYC : SRR_CYC;

	sps_host_s h;
	sps_host_s next_h;
	logic      halfDone;

	assign halfDone = (h.divCnt >= 8'(SCLK_HALF - 1));

	// =====================================================================
	// next state
	always_comb
	begin
		next_h = h;
		next_h.sdioS   = {h.sdioS[0], link.sdio};
		next_h.rdValid = 1'b0;

		// sleep pin: a short request is stretched to reset the port
		if (sleepReq || (h.sleepPin && h.sleepCnt < PD_RST_CYC))
		begin
			next_h.sleepPin = 1'b1;
		end
		else
		begin
			next_h.sleepPin = 1'b0;
		end
		next_h.sleepCnt = h.sleepPin ? 32'(h.sleepCnt + 32'h1) : 32'h0;
		if (h.sleepPin && h.sleepCnt == 32'hffffffff)
		begin
			next_h.sleepCnt = h.sleepCnt;
		end

		case (h.st)
			HS_IDLE:
			begin
				if (cmdValid && !h.sleepPin)
				begin
					next_h.st      = HS_ADDR;
					next_h.isWrite = cmdWrite;
					next_h.wdata   = cmdData;
					next_h.shift   = {cmdWrite, cmdAddr};
					next_h.sdoOeN  = 1'b0;
					next_h.divCnt  = 8'h00;
					next_h.bitCnt  = 4'h0;
				end
			end
			HS_ADDR, HS_WDATA, HS_RDATA:
			begin
				// sclk half period keeps it below a quarter of the device clock
				next_h.divCnt = 8'(h.divCnt + 8'h01);
				if (halfDone)
				begin
					next_h.divCnt = 8'h00;
					next_h.sclk   = ~h.sclk;
					if (h.sclk)
					begin
						// falling edge: nothing to do, data already stands on shift[7]
						next_h.sclk = 1'b0;
					end
					else
					begin
						next_h.shift  = {h.shift[6:0], h.sdioS[1]};
						next_h.bitCnt = 4'(h.bitCnt + 4'h1);
						if (h.bitCnt == 4'(LAST_BIT))
						begin
							next_h.bitCnt = 4'h0;
							next_h.gapCnt = 32'h0;
							if (h.st == HS_ADDR && h.isWrite)
							begin
								next_h.st    = HS_WDATA;
								next_h.shift = h.wdata;
							end
							else if (h.st == HS_ADDR)
							begin
								next_h.st     = HS_HOLD;
								next_h.sdoOeN = 1'b1;
							end
							else if (h.st == HS_WDATA)
							begin
								next_h.st     = HS_GAP;
								next_h.sdoOeN = 1'b1;
								next_h.gapLen = AFTER_WRITE;
							end
							else
							begin
								next_h.st      = HS_GAP;
								next_h.rdData  = next_h.shift;
								next_h.rdValid = 1'b1;
								next_h.gapLen  = AFTER_READ;
							end
						end
					end
				end
			end
			HS_HOLD:
			begin
				next_h.gapCnt = 32'(h.gapCnt + 32'h1);
				if (h.gapCnt >= HOLD_CYC - 1)
				begin
					next_h.st     = HS_RDATA;
					next_h.divCnt = 8'h00;
				end
			end
			HS_GAP:
			begin
				next_h.gapCnt = 32'(h.gapCnt + 32'h1);
				if (h.gapCnt >= h.gapLen - 1)
				begin
					next_h.st = HS_IDLE;
				end
			end
			default: next_h.st = HS_IDLE;
		endcase

		// the device drops its port on a sleep pulse, so abandon the transfer
		if (h.sleepPin && h.st != HS_IDLE)
		begin
			next_h.st      = HS_IDLE;
			next_h.sclk    = 1'b1;
			next_h.sdoOeN  = 1'b1;
			next_h.rdValid = 1'b0;
		end
	end

	// =====================================================================
	// state register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			h        <= '0;
			h.st     <= HS_IDLE;
			h.sclk   <= 1'b1;
			h.sdoOeN <= 1'b1;
		end
		else
		begin
			h <= next_h;
		end
	end

	assign link.sclk            = h.sclk;
	assign link.sdioHost        = h.shift[7];
	assign link.sdioHostOeN     = h.sdoOeN;
	assign link.sleepRequestPin = h.sleepPin;
	assign cmdReady             = (h.st == HS_IDLE) && !h.sleepPin;
	assign rdData               = h.rdData;
	assign rdValid              = h.rdValid;
	// long enough for the device to power down
	assign sleepLong            = h.sleepPin && (h.sleepCnt >= PDW_CYC);
endmodule

// *** tb/sps_link_checker.sv ***
// link checker: serial spacing, sleep pin and quadrature behaviour
`timescale 1ns/100ps
module sps_link_checker #(
	parameter int unsigned SWW_CYC    = 40,
	parameter int unsigned SRR_CYC    = 15,
	parameter int unsigned PD_RST_CYC = 50
) (
	input logic mclk,
	input logic rst_n,
	input logic sclk,
	input logic sdio,
	input logic sdioHostOeN,
	input logic sdioDevOeN,
	input logic sleepRequestPin,
	input logic horizontalPhaseA,
	input logic horizontalPhaseB,
	input logic verticalPhaseA,
	input logic verticalPhaseB
);
	logic        sclkQ;
	logic        sdioQ;
	logic        isWrite;
	logic        lastWrite;
	logic [4:0]  bitCnt;
	logic [15:0] highCnt;
	logic [15:0] pinCnt;
	logic [3:0]  phases;
	assign phases = {horizontalPhaseA, horizontalPhaseB, verticalPhaseA, verticalPhaseB};
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// =====
	// bit and gap tracking
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclkQ <= 1'b1;
			sdioQ <= 1'b1;
			isWrite <= 1'b0;
			lastWrite <= 1'b0;
			bitCnt <= 5'h00;
			highCnt <= 16'hffff;
			pinCnt <= 16'h0000;
		end
		else
		begin
			sclkQ <= sclk;
			sdioQ <= sdio;
			pinCnt <= sleepRequestPin ? pinCnt + 16'h0001 : 16'h0000;
			highCnt <= sclk ? highCnt + {15'h0000, highCnt != 16'hffff} : 16'h0000;
			// an aborted transfer owes no write gap
			if (sleepRequestPin)
			begin
				bitCnt <= 5'h00;
				lastWrite <= 1'b0;
			end
			else if (sclk && !sclkQ)
			begin
				if (bitCnt == 5'h00)
					// host moves data on the rise, so take the bit from before it
					isWrite <= sdioQ;
				if (bitCnt == 5'h0f)
					lastWrite <= isWrite;
				bitCnt <= (bitCnt == 5'h0f) ? 5'h00 : bitCnt + 5'h01;
			end
		end
	end
	// =====
	// assertions
	a_sclk_quarter_rate:
	assert property ($changed(sclk) |=> $stable(sclk)[*3]) else $error("sclk too fast");
	a_write_gap:
	assert property ($fell(sclk) && bitCnt == 5'h00 && lastWrite |-> highCnt >= SWW_CYC)
		else $error("gap after write too short");
	a_read_gap:
	assert property ($fell(sclk) && bitCnt == 5'h00 && !lastWrite |-> highCnt >= SRR_CYC)
		else $error("gap after read too short");
	a_no_contention:
	assert property (!sdioDevOeN |-> sdioHostOeN) else $error("both ends drive data");
	a_sleep_hold:
	assert property ($fell(sleepRequestPin) |-> pinCnt >= PD_RST_CYC)
		else $error("sleep pulse too short");
	a_port_reset_sleep:
	assert property (pinCnt >= PD_RST_CYC + 5 |-> sdioDevOeN)
		else $error("port not reset by sleep pulse");
	a_host_idle_sleep:
	assert property (sleepRequestPin && pinCnt >= 16'h0003 |-> sclk && sdioHostOeN)
		else $error("host still clocking in sleep");
	a_quad_frozen:
	assert property (sleepRequestPin && $past(sleepRequestPin, 6) |-> $stable(phases))
		else $error("quadrature moved in sleep");
endmodule

// *** tb/sps_tb_top.sv ***
// testbench: host and sensor ends joined, plus a bench-driven sensor
`timescale 1ns/100ps
module sps_tb_top;
	import sps_pkg::*;
	localparam int unsigned FR  = 200;
	localparam int unsigned PDR = 50;
	localparam int unsigned PDN = 100;
	localparam int unsigned WK  = 100;
	localparam int unsigned CMP = 300;
	localparam int unsigned GAP = 40;
	localparam int unsigned SPT = 2000;
	localparam int unsigned STP = 20;
	logic       mclk, rst_n, cmdValid, cmdWrite, cmdReady, rdValid;
	logic       sleepReq, sleepLong, motionValid, pdB;
	logic       quadValid, dataReady, poweredDown, frameTick;
	logic [6:0] cmdAddr;
	logic [7:0] cmdData, rdData, dX, dY;
	logic [3:0] phases;
	int         err_total, n_checks, t, t2, nFrames;
	sps_if link();
	sps_if linkB();
	assign phases = {link.horizontalPhaseA, link.horizontalPhaseB, link.verticalPhaseA,
		link.verticalPhaseB};
	sps_host_end #(.SWR_CYC(GAP), .SWW_CYC(GAP), .HOLD_CYC(GAP), .PD_RST_CYC(PDR),
		.PDW_CYC(PDN)) i_sps_host_end (.mclk(mclk), .rst_n(rst_n), .link(link.host),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid), .sleepReq(sleepReq),
		.sleepLong(sleepLong));
	sps_device_end #(.FRAME_CYC(FR), .COMPUTE_CYC(CMP), .PD_RST_CYC(PDR), .PDOWN_CYC(PDN),
		.WAKE_CYC(WK), .SPTT_CYC(SPT), .STEP_CYC(STP)) i_sps_device_end (.mclk(mclk),
		.rst_n(rst_n), .link(link.dev), .motionValid(motionValid), .deltaX(dX), .deltaY(dY),
		.quadValid(quadValid), .dataReady(dataReady), .poweredDown(poweredDown),
		.frameTick(frameTick));
	// second sensor faces the bench, which breaks the host side on purpose
	sps_device_end #(.FRAME_CYC(FR), .COMPUTE_CYC(CMP), .PD_RST_CYC(PDR), .PDOWN_CYC(PDN),
		.WAKE_CYC(WK), .SPTT_CYC(SPT), .STEP_CYC(STP)) i_sps_device_end_b (.mclk(mclk),
		.rst_n(rst_n), .link(linkB.dev), .motionValid(motionValid), .deltaX(dX), .deltaY(dY),
		.quadValid(), .dataReady(), .poweredDown(pdB), .frameTick());
	sps_link_checker #(.SWW_CYC(GAP), .SRR_CYC(SRR_CYC), .PD_RST_CYC(PDR)) i_chk (
		.mclk(mclk), .rst_n(rst_n), .sclk(link.sclk), .sdio(link.sdio),
		.sdioHostOeN(link.sdioHostOeN), .sdioDevOeN(link.sdioDevOeN),
		.sleepRequestPin(link.sleepRequestPin), .horizontalPhaseA(link.horizontalPhaseA),
		.horizontalPhaseB(link.horizontalPhaseB), .verticalPhaseA(link.verticalPhaseA),
		.verticalPhaseB(link.verticalPhaseB));
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// counted mid-cycle, away from the edge that launches the pulse
	always @(negedge mclk)
		if (frameTick === 1'b1)
			nFrames++;
	// =====
	// tasks
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// sampled at the falling edge so settled values are seen
	task automatic waitFor(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim)
		begin
			@(negedge mclk);
			n++;
		end
	endtask
	task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
		int n;
		@(negedge mclk);
		waitFor(cmdReady, 20000, n);
		@(posedge mclk);
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdAddr <= a;
		cmdData <= d;
		@(posedge mclk);
		cmdValid <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		int n;
		cmd(1'b0, a, 8'h00);
		waitFor(rdValid, 2000, n);
		chk({8'h00, rdData}, {8'h00, exp});
	endtask
	task automatic tick(output int n);
		waitFor(frameTick, 2000, n);
		@(negedge mclk);
	endtask
	task automatic bbOut(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			linkB.sclk <= 1'b0;
			linkB.sdioHostOeN <= 1'b0;
			linkB.sdioHost <= b[7 - i];
			repeat (8) @(posedge mclk);
			linkB.sclk <= 1'b1;
			repeat (7) @(posedge mclk);
		end
		linkB.sdioHostOeN <= 1'b1;
	endtask
	task automatic bbId;
		logic [7:0] v;
		bbOut(8'h00, 8);
		repeat (GAP) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			linkB.sclk <= 1'b0;
			repeat (8) @(posedge mclk);
			v[7 - i] = linkB.sdio;
			linkB.sclk <= 1'b1;
			repeat (8) @(posedge mclk);
		end
		chk({8'h00, v}, {8'h00, ID_VALUE});
	endtask
	// =====
	// main sequence
	initial
	begin
		{err_total, n_checks, nFrames} = '0;
		{rst_n, cmdValid, cmdWrite, sleepReq, motionValid} = '0;
		{cmdAddr, cmdData, dX, dY} = '0;
		{linkB.sclk, linkB.sdioHostOeN, linkB.sdioHost, linkB.sleepRequestPin} = 4'b1100;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		waitFor(quadValid, 9000, t);
		chk(16'(t <= WK + 40 * FR + 20), 16'h0001);
		rd(7'h00, ID_VALUE);
		rd(7'h01, 8'h03);
		cmd(1'b1, 7'h04, 8'h01);
		rd(7'h04, 8'h01);
		tick(t);
		tick(t);
		tick(t);
		chk(16'(t), 16'(FR + 255));
		cmd(1'b1, 7'h04, 8'h00);
		cmd(1'b1, 7'h04, 8'h00);
		rd(7'h04, 8'h00);
		@(posedge mclk);
		motionValid <= 1'b1;
		dX <= 8'h05;
		dY <= 8'hfd;
		@(posedge mclk);
		motionValid <= 1'b0;
		repeat (40) @(posedge mclk);
		sleepReq <= 1'b1;
		@(posedge mclk);
		sleepReq <= 1'b0;
		repeat (120) @(posedge mclk);
		chk({14'h0, poweredDown, quadValid}, 16'h0001);
		cmd(1'b0, 7'h00, 8'h00);
		repeat (200) @(posedge mclk);
		sleepReq <= 1'b1;
		waitFor(sleepLong, 300, t);
		chk(16'(t + 2 >= PDN && t <= PDN + 2), 16'h0001);
		waitFor(poweredDown, 300, t2);
		chk(16'(t + t2 >= PDN && t + t2 <= PDN + 8), 16'h0001);
		chk({15'h0, quadValid}, 16'h0000);
		@(posedge mclk);
		sleepReq <= 1'b0;
		nFrames = 0;
		waitFor(dataReady, 2000, t);
		chk(16'(t <= CMP + 2 * FR), 16'h0001);
		waitFor(quadValid, 16000, t2);
		chk(16'(t + t2 <= WK + 75 * FR + 20), 16'h0001);
		chk(16'(nFrames >= 75), 16'h0001);
		rd(7'h00, ID_VALUE);
		// +5 in x ends one step past the zero phase, -3 in y one step short of it; both sit at phase 1
		chk({12'h000, phases}, 16'h0005);
		bbOut(8'hff, 3);
		repeat (2100) @(posedge mclk);
		bbId;
		bbOut(8'hff, 3);
		linkB.sleepRequestPin <= 1'b1;
		repeat (60) @(posedge mclk);
		linkB.sleepRequestPin <= 1'b0;
		repeat (10) @(posedge mclk);
		bbId;
		chk({15'h0, pdB}, 16'h0000);
		close_out;
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		err_total++;
		close_out;
	end
endmodule
